// >>> design/uefc_endpoint_ctrl.sv
// Endpoint FIFO control: enables, stall, data toggles, FIFO pairing, setup buffer.
// Assumes the serial engine runs on i_ref_clk and gives one event pulse at a time.
//
// Behaviour
// - Endpoints 1-4 use own FIFOs or pair them for double buffering.
// - Four pair choices: IN 1+2, OUT 1+2, IN 3+4, OUT 3+4.
// - A pair is seen only through its odd FIFO; the even one serves only as its second buffer.
// - Each packet size write on a pair swaps the processor's buffer.
// - Engine uses one buffer of a pair while processor uses the other.
// - Unpaired IN answers NAK until loaded, then sends data.
// - Endpoint control acts on and reports the selected endpoint FIFO.
// - Control bit 3 enables the FIFO; all enabled after reset.
// - Control bit 2 set makes OUT packets, and IN tokens to an enabled FIFO, get STALL.
// - IN toggle picks DATA0/DATA1, flips only on a host ACK.
// - OUT toggle is the expected PID, flips on good OUT packet.
// - OUT with wrong toggle is a retry: ACK, no interrupt.
// - Engine off then on clears every toggle.
// - FIFO enable going 0 to 1 clears that FIFO's toggle.
// - Setup packet's eight bytes kept in a command buffer.
// - Index bits 2:0 choose which setup byte the value register shows.
`timescale 1ns/1ps
`default_nettype none
module uefc_endpoint_ctrl #(
    parameter int NUM_BYTES = uefc_pkg::SETUP_BYTES
) (
    input  wire logic                       i_ref_clk,      // 25 MHz clock
    input  wire logic                       i_rst,          // Sync reset, high
    input  wire logic                       i_ce,           // Clock enable
    input  wire logic                       i_psel,         // APB select
    input  wire logic                       i_penable,      // APB enable
    input  wire logic                       i_pwrite,       // APB write
    input  wire logic [uefc_pkg::ADDR_W-1:0] i_paddr,       // APB byte address
    input  wire logic [31:0]                i_pwdata,       // APB write data
    output logic [31:0]                     o_prdata,       // APB read data
    output logic                            o_pready,       // APB ready
    output logic                            o_pslverr,      // Unmapped address
    input  wire logic                       i_tok_in,       // IN token pulse
    input  wire logic                       i_in_ack,       // Host ACK after data
    input  wire logic                       i_rx_done,      // OUT/setup packet end
    input  wire logic                       i_rx_crc_ok,    // Packet CRC good
    input  wire logic                       i_rx_data1,     // Packet PID is DATA1
    input  wire logic                       i_rx_setup,     // Packet is setup data
    input  wire logic [uefc_pkg::EP_W-1:0]  i_ep,           // Endpoint of event
    input  wire logic                       i_rx_byte_valid,// Setup byte strobe
    input  wire logic [7:0]                 i_rx_byte,      // Setup byte
    output logic                            o_hs_valid,     // Answer pulse
    output logic [1:0]                      o_hs_code,      // Answer kind
    output logic                            o_tx_data1,     // Send DATA1 PID
    output logic [uefc_pkg::EP_W-1:0]       o_fifo_ep,      // Physical FIFO used
    output logic                            o_engine_en,    // Engine enable
    output logic                            o_irq           // Interrupt, high
);
    localparam int NS = uefc_pkg::NUM_SLOT;
    localparam logic [2:0] EP_ONE_W = uefc_pkg::EP_ONE;

    function automatic logic [uefc_pkg::SLOT_W-1:0] slot_of(input logic dir,
                                                            input logic [2:0] ep);
        slot_of = dir ? uefc_pkg::IN_SLOT_BASE + {1'b0, ep} : {1'b0, ep};
    endfunction : slot_of

    function automatic logic [1:0] pidx_of(input logic dir, input logic [2:0] ep);
        pidx_of = {ep > uefc_pkg::EP_TWO, ~dir};
    endfunction : pidx_of

    // Pairing bits: 0 IN 1+2, 1 OUT 1+2, 2 IN 3+4, 3 OUT 3+4
    function automatic logic paired_of(input logic [3:0] pr, input logic dir,
                                       input logic [2:0] ep);
        paired_of = (ep != 3'h0) && (ep < 3'(uefc_pkg::NUM_EP)) && pr[pidx_of(dir, ep)];
    endfunction : paired_of

    logic [7:0]        ep_sel;
    logic [3:0]        pairing;
    logic [6:0]        pkt_size;
    logic              eng_en;
    logic [2:0]        setup_ix;
    logic [3:0]        int_stat;
    logic [3:0]        int_mask;
    logic [NS-1:0]     en, stall, tog, busy;
    logic [3:0]        cpu_sel, sie_sel;
    logic [7:0]        setup_buf [NUM_BYTES];
    logic [2:0]        setup_cnt;

    // Bus decode
    wire hit_sel  = i_paddr == uefc_pkg::addr_of(uefc_pkg::IDX_EP_SEL);
    wire hit_ctrl = i_paddr == uefc_pkg::addr_of(uefc_pkg::IDX_EP_CTRL);
    wire hit_pair = i_paddr == uefc_pkg::addr_of(uefc_pkg::IDX_PAIRING);
    wire hit_size = i_paddr == uefc_pkg::addr_of(uefc_pkg::IDX_PKT_SIZE);
    wire hit_link = i_paddr == uefc_pkg::addr_of(uefc_pkg::IDX_LINK);
    wire hit_six  = i_paddr == uefc_pkg::addr_of(uefc_pkg::IDX_SETUP_IX);
    wire hit_sval = i_paddr == uefc_pkg::addr_of(uefc_pkg::IDX_SETUP_V);
    wire hit_ist  = i_paddr == uefc_pkg::addr_of(uefc_pkg::IDX_INT_STAT);
    wire hit_imk  = i_paddr == uefc_pkg::addr_of(uefc_pkg::IDX_INT_MASK);
    wire mapped   = hit_sel | hit_ctrl | hit_pair | hit_size | hit_link
                  | hit_six | hit_sval | hit_ist | hit_imk;
    wire setup_ph = i_psel & ~i_penable;
    wire wr       = i_psel & i_penable & o_pready & i_pwrite & mapped;
    wire [7:0] wd = i_pwdata[7:0];

    // Processor side view of the selected endpoint
    wire       c_dir    = ep_sel[uefc_pkg::SEL_DIR];
    wire [2:0] c_ep     = ep_sel[2:0];
    wire       c_valid  = c_ep < 3'(uefc_pkg::NUM_EP);
    wire       c_odd    = (c_ep == uefc_pkg::EP_ODD_LO) || (c_ep == uefc_pkg::EP_ODD_HI);
    wire       c_pair   = paired_of(pairing, c_dir, c_ep);
    wire       c_block  = ~c_valid | (c_pair & ~c_odd);
    wire [1:0] c_pidx   = pidx_of(c_dir, c_ep);
    wire [2:0] c_pep    = (c_pair & cpu_sel[c_pidx]) ? c_ep + EP_ONE_W : c_ep;
    wire [3:0] c_slot   = slot_of(c_dir, c_ep);
    wire [3:0] c_phys   = slot_of(c_dir, c_pep);
    wire       wr_ctrl  = wr & hit_ctrl & ~c_block;
    wire       wr_size  = wr & hit_size & ~c_block;

    // Engine side view of the event endpoint
    wire       e_dir    = i_tok_in | i_in_ack;
    wire       e_valid  = i_ep < 3'(uefc_pkg::NUM_EP);
    wire       e_odd    = (i_ep == uefc_pkg::EP_ODD_LO) || (i_ep == uefc_pkg::EP_ODD_HI);
    wire       e_pair   = paired_of(pairing, e_dir, i_ep);
    wire       e_ok     = e_valid & ~(e_pair & ~e_odd);
    wire [1:0] e_pidx   = pidx_of(e_dir, i_ep);
    wire [2:0] e_pep    = (e_pair & sie_sel[e_pidx]) ? i_ep + EP_ONE_W : i_ep;
    wire [3:0] e_slot   = slot_of(e_dir, i_ep);
    wire [3:0] e_phys   = slot_of(e_dir, e_pep);
    wire       out_pkt  = i_rx_done & i_rx_crc_ok & ~i_rx_setup & e_ok;
    wire       out_retx = out_pkt & ~stall[e_slot] & en[e_slot]
                        & (i_rx_data1 != tog[e_slot]);
    wire       out_take = out_pkt & ~stall[e_slot] & en[e_slot] & ~out_retx
                        & ~busy[e_phys];
    wire       in_done  = i_in_ack & e_ok & busy[e_phys];
    wire       setup_ok = i_rx_done & i_rx_crc_ok & i_rx_setup;
    wire       stalled  = ((i_tok_in & e_ok) | out_pkt) & stall[e_slot];
    wire       restart  = wr & hit_link & wd[uefc_pkg::LINK_EN] & ~eng_en;

    // Answer to the serial engine
    logic      next_hs_valid;
    uefc_pkg::uefc_hs_t next_hs;
    always_comb begin
        next_hs_valid = 1'b0;
        next_hs       = uefc_pkg::HS_NAK;
        if (i_tok_in) begin
            next_hs_valid = 1'b1;
            if (!e_ok || !en[e_slot])
                next_hs = uefc_pkg::HS_NAK;
            else if (stall[e_slot])
                next_hs = uefc_pkg::HS_STALL;
            else if (busy[e_phys])
                next_hs = uefc_pkg::HS_DATA;
            else
                next_hs = uefc_pkg::HS_NAK;
        end else if (setup_ok) begin
            next_hs_valid = 1'b1;
            next_hs       = uefc_pkg::HS_ACK;
        end else if (i_rx_done && i_rx_crc_ok) begin
            next_hs_valid = 1'b1;
            if (stalled)
                next_hs = uefc_pkg::HS_STALL;
            else if (out_retx || out_take)
                next_hs = uefc_pkg::HS_ACK;
            else
                next_hs = uefc_pkg::HS_NAK;
        end
    end

    // Per-FIFO state; engine events override a same-cycle control or size write; a restart wins over both
    logic [NS-1:0] next_en, next_stall, next_tog, next_busy;
    logic [3:0]    next_cpu_sel, next_sie_sel;
    always_comb begin
        next_en      = en;
        next_stall   = stall;
        next_tog     = tog;
        next_busy    = busy;
        next_cpu_sel = cpu_sel;
        next_sie_sel = sie_sel;
        if (wr_ctrl) begin
            next_en[c_slot]    = wd[uefc_pkg::CTRL_EN];
            next_stall[c_slot] = wd[uefc_pkg::CTRL_STALL];
            next_tog[c_slot]   = wd[uefc_pkg::CTRL_TOG];
            if (wd[uefc_pkg::CTRL_EN] && !en[c_slot])
                next_tog[c_slot] = 1'b0;
        end
        if (wr_size) begin
            next_busy[c_phys] = c_dir;  // IN: loaded, OUT: released
            if (c_pair)
                next_cpu_sel[c_pidx] = ~cpu_sel[c_pidx];
        end
        if (out_take || in_done) begin
            next_busy[e_phys] = out_take;
            next_tog[e_slot]  = ~tog[e_slot];
            if (e_pair)
                next_sie_sel[e_pidx] = ~sie_sel[e_pidx];
        end
        if (restart)
            next_tog = '0;
    end

    wire [3:0] int_set = {stalled, setup_ok, out_take, in_done};

    // Register read mux
    logic [7:0] rd;
    always_comb begin
        rd = 8'h00;
        if (hit_sel)  rd = ep_sel;
        if (hit_ctrl && !c_block)
            rd = {4'h0, en[c_slot], stall[c_slot], tog[c_slot], busy[c_phys]};
        if (hit_pair) rd = {4'h0, pairing};
        if (hit_size) rd = {1'b0, pkt_size};
        if (hit_link) rd = {7'h00, eng_en};
        if (hit_six)  rd = {5'h00, setup_ix};
        if (hit_sval) rd = setup_buf[setup_ix];
        if (hit_ist)  rd = {4'h0, int_stat};
        if (hit_imk)  rd = {4'h0, int_mask};
    end

    // Bus slave: one wait-free access phase after each setup cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else if (i_ce) begin
            o_pready  <= setup_ph;
            o_pslverr <= setup_ph & ~mapped;
            if (setup_ph)
                o_prdata <= {24'h00_0000, rd};
        end
    end

    // Software registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ep_sel   <= 8'h00;
            pairing  <= 4'h0;
            pkt_size <= uefc_pkg::SIZE_RESET;
            eng_en   <= 1'b0;
            setup_ix <= 3'h0;
            int_mask <= 4'h0;
        end else if (i_ce && wr) begin
            if (hit_sel)  ep_sel   <= {wd[uefc_pkg::SEL_DIR], 4'h0, wd[2:0]};
            if (hit_pair) pairing  <= wd[3:0];
            if (hit_size) pkt_size <= wd[6:0];
            if (hit_link) eng_en   <= wd[uefc_pkg::LINK_EN];
            if (hit_six)  setup_ix <= wd[2:0];
            if (hit_imk)  int_mask <= wd[3:0];
        end
    end

    // Endpoint state, reset leaves every FIFO enabled
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            en      <= '1;
            stall   <= '0;
            tog     <= '0;
            busy    <= '0;
            cpu_sel <= 4'h0;
            sie_sel <= 4'h0;
        end else if (i_ce) begin
            en      <= next_en;
            stall   <= next_stall;
            tog     <= next_tog;
            busy    <= next_busy;
            cpu_sel <= next_cpu_sel;
            sie_sel <= next_sie_sel;
        end
    end

    // Setup bytes land in arrival order; the counter rearms at packet end
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            setup_cnt <= 3'h0;
        end else if (i_ce) begin
            if (i_rx_done)
                setup_cnt <= 3'h0;
            else if (i_rx_byte_valid && i_rx_setup)
                setup_cnt <= setup_cnt + 3'h1;
        end
    end

    // Cleared on reset so the value register reads zero before any setup packet
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int k = 0; k < NUM_BYTES; k++)
                setup_buf[k] <= 8'h00;
        end else if (i_ce) begin
            if (i_rx_byte_valid && i_rx_setup)
                setup_buf[setup_cnt] <= i_rx_byte;
            else if (wr && hit_sval)
                setup_buf[setup_ix] <= wd;
        end
    end

    // Interrupts: sticky, write one to clear, a new event wins over the clear
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            int_stat <= 4'h0;
            o_irq    <= 1'b0;
        end else if (i_ce) begin
            int_stat <= (int_stat & ~((wr & hit_ist) ? wd[3:0] : 4'h0)) | int_set;
            o_irq    <= |(int_stat & int_mask);
        end
    end

    // Engine outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_hs_valid  <= 1'b0;
            o_hs_code   <= 2'h0;
            o_tx_data1  <= 1'b0;
            o_fifo_ep   <= 3'h0;
            o_engine_en <= 1'b0;
        end else if (i_ce) begin
            o_hs_valid  <= next_hs_valid;
            o_hs_code   <= next_hs;
            o_tx_data1  <= tog[e_slot];
            o_fifo_ep   <= e_pep;
            o_engine_en <= eng_en;
        end
    end

    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_in_stalled;
        i_ce && i_tok_in && e_ok && en[e_slot] && stall[e_slot];
    endsequence
    sequence s_in_empty;
        i_ce && i_tok_in && e_ok && en[e_slot] && !stall[e_slot] && !busy[e_phys];
    endsequence
    sequence s_in_loaded;
        i_ce && i_tok_in && e_ok && en[e_slot] && !stall[e_slot] && busy[e_phys];
    endsequence

    a_stall_answer: assert property (s_in_stalled
                                     |=> o_hs_valid && o_hs_code == uefc_pkg::HS_STALL)
        else $error("stalled IN token not answered with STALL");
    a_nak_empty: assert property (s_in_empty
                                  |=> o_hs_valid && o_hs_code == uefc_pkg::HS_NAK)
        else $error("IN token on empty FIFO not answered with NAK");
    a_data_loaded: assert property (s_in_loaded
                                    |=> o_hs_valid && o_hs_code == uefc_pkg::HS_DATA)
        else $error("loaded IN FIFO not answered with data");
    a_data_pid: assert property (i_ce && i_tok_in && next_hs == uefc_pkg::HS_DATA
                                 |=> o_tx_data1 == $past(tog[e_slot]))
        else $error("data PID does not follow toggle");
    a_in_toggle: assert property (i_ce && in_done && !restart |=> tog != $past(tog))
        else $error("toggle did not flip on host ACK");
    a_out_toggle: assert property (i_ce && out_take && !restart |=> tog != $past(tog))
        else $error("toggle did not flip on good OUT packet");
    a_retx_quiet: assert property (i_ce && out_retx
                                   |=> o_hs_valid && o_hs_code == uefc_pkg::HS_ACK
                                   && (!int_stat[uefc_pkg::INT_OUT_DONE]
                                       || $past(int_stat[uefc_pkg::INT_OUT_DONE])))
        else $error("retransmission raised an interrupt or missed ACK");
    a_enable_clr: assert property (i_ce && wr_ctrl && wd[uefc_pkg::CTRL_EN] && !en[c_slot]
                                   && !out_take && !in_done && !restart
                                   |=> !tog[$past(c_slot)])
        else $error("enabling a FIFO left its toggle set");
    a_pair_swap: assert property (i_ce && wr_size && c_pair |=> cpu_sel != $past(cpu_sel))
        else $error("packet size write did not swap buffer");
    a_restart_clr: assert property (i_ce && restart |=> tog == '0)
        else $error("engine restart left a toggle set");
    a_setup_store: assert property (i_ce && i_rx_byte_valid && i_rx_setup
                                    |=> setup_buf[$past(setup_cnt)] == $past(i_rx_byte))
        else $error("setup byte not stored in arrival order");
    a_setup_read: assert property (i_ce && setup_ph && hit_sval
                                   |=> o_prdata[7:0] == $past(setup_buf[setup_ix]) && o_pready)
        else $error("setup value read wrong byte");
    a_rsvd_zero: assert property (i_ce && setup_ph && hit_six |=> o_prdata[7:3] == 5'h00)
        else $error("reserved index bits read nonzero");
    a_even_hidden: assert property (i_ce && wr && hit_ctrl && c_pair && !c_odd
                                    |=> $stable(en) && $stable(stall))
        else $error("write reached hidden even FIFO");
endmodule : uefc_endpoint_ctrl
`default_nettype wire

// >>> shared/uefc_pkg.sv
// Constants for the USB endpoint FIFO control block.
// Assumes a 32-bit APB slave; each register sits in one word at index*4.
package uefc_pkg;
    localparam int             ADDR_W       = 10;
    localparam int             EP_W         = 3;
    localparam int             SLOT_W       = 4;
    localparam int             NUM_EP       = 5;
    localparam int             NUM_SLOT     = 10;
    localparam int             SETUP_BYTES  = 8;
    localparam int             INT_W        = 4;
    // Register indices; byte address is four times the index
    localparam logic [7:0]     IDX_EP_SEL   = 8'hF0;
    localparam logic [7:0]     IDX_EP_CTRL  = 8'hF1;
    localparam logic [7:0]     IDX_PAIRING  = 8'hF2;
    localparam logic [7:0]     IDX_PKT_SIZE = 8'hF3;
    localparam logic [7:0]     IDX_LINK     = 8'hF4;
    localparam logic [7:0]     IDX_SETUP_IX = 8'hF5;
    localparam logic [7:0]     IDX_SETUP_V  = 8'hF6;
    localparam logic [7:0]     IDX_INT_STAT = 8'hF7;
    localparam logic [7:0]     IDX_INT_MASK = 8'hF8;
    // Field positions
    localparam int             CTRL_EN      = 3;
    localparam int             CTRL_STALL   = 2;
    localparam int             CTRL_TOG     = 1;
    localparam int             CTRL_BUSY    = 0;
    localparam int             SEL_DIR      = 7;
    localparam int             LINK_EN      = 0;
    localparam int             INT_IN_DONE  = 0;
    localparam int             INT_OUT_DONE = 1;
    localparam int             INT_SETUP    = 2;
    localparam int             INT_STALL    = 3;
    localparam logic [7:0]     CTRL_RESET   = 8'h08;
    localparam logic [6:0]     SIZE_RESET   = 7'h00;
    localparam logic [2:0]     EP_ODD_LO    = 3'h1;
    localparam logic [2:0]     EP_ODD_HI    = 3'h3;
    localparam logic [2:0]     EP_ONE       = 3'h1;
    localparam logic [2:0]     EP_TWO       = 3'h2;
    localparam logic [3:0]     IN_SLOT_BASE = 4'h5;

    typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL, HS_DATA} uefc_hs_t;

    function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
        addr_of = {idx, 2'b00};
    endfunction : addr_of
endpackage : uefc_pkg

// >>> bench/uefc_host_model.sv
// Host controller model: issues tokens, packets and setup bytes, samples answers.
// Assumes its tasks are entered right after a rising edge of i_ref_clk.
`timescale 1ns/1ps
`default_nettype none
module uefc_host_model (
    input  wire logic       i_ref_clk,  // Clock
    input  wire logic       i_hs_valid, // Answer pulse
    input  wire logic [1:0] i_hs_code,  // Answer kind
    input  wire logic       i_tx_data1, // PID of sent data
    input  wire logic [2:0] i_fifo_ep,  // Physical FIFO used
    output logic            o_tok_in,   // IN token
    output logic            o_in_ack,   // Host ACK
    output logic            o_rx_done,  // Packet end
    output logic            o_crc_ok,   // CRC good
    output logic            o_data1,    // DATA1 PID
    output logic            o_setup,    // Setup packet
    output logic [2:0]      o_ep,       // Endpoint
    output logic            o_byte_vld, // Byte strobe
    output logic [7:0]      o_byte      // Setup byte
);
    initial begin
        {o_tok_in, o_in_ack, o_rx_done, o_crc_ok, o_data1, o_setup, o_byte_vld} = 7'h00;
        o_ep = 3'h0;
        o_byte = 8'h00;
    end
    // Kind 0 token, 1 ack, 2 OUT packet, 3 setup packet end
    task automatic ev(input logic [2:0] kind, input logic [2:0] ep, input logic d1,
                      output logic [2:0] ans, output logic tx1, output logic [2:0] fep);
        o_ep <= ep;
        o_data1 <= d1;
        o_crc_ok <= 1'b1;
        o_setup <= (kind == 3'h3);
        o_tok_in <= (kind == 3'h0);
        o_in_ack <= (kind == 3'h1);
        o_rx_done <= kind[1];
        @(posedge i_ref_clk);
        {o_tok_in, o_in_ack, o_rx_done, o_setup} <= 4'h0;
        // Qualifiers are meaningless once the pulse is gone
        o_ep <= ~ep;
        o_data1 <= ~d1;
        @(posedge i_ref_clk);
        ans = {i_hs_valid, i_hs_code};
        tx1 = i_tx_data1;
        fep = i_fifo_ep;
    endtask : ev
    task automatic bytes(input logic [7:0] base);
        o_setup <= 1'b1;
        o_ep <= 3'h0;
        for (int k = 0; k < 8; k++) begin
            o_byte_vld <= 1'b1;
            o_byte <= base + 8'(k);
            @(posedge i_ref_clk);
        end
        o_byte_vld <= 1'b0;
        o_byte <= ~(base + 8'h07);
    endtask : bytes
endmodule : uefc_host_model
`default_nettype wire

// >>> bench/usb_endpoint_fifo_control_tb.sv
// Self-checking bench: APB register tasks plus host model events.
// Assumes one 25 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_fifo_control_tb;
    localparam logic [7:0] SEL = uefc_pkg::IDX_EP_SEL, CTL = uefc_pkg::IDX_EP_CTRL,
        PAIR = uefc_pkg::IDX_PAIRING, SIZE = uefc_pkg::IDX_PKT_SIZE,
        LINK = uefc_pkg::IDX_LINK, SIX = uefc_pkg::IDX_SETUP_IX, SV = uefc_pkg::IDX_SETUP_V,
        IST = uefc_pkg::IDX_INT_STAT, IMSK = uefc_pkg::IDX_INT_MASK;
    localparam logic [1:0] ACK = uefc_pkg::HS_ACK, NAK = uefc_pkg::HS_NAK,
        STALL = uefc_pkg::HS_STALL, DATA = uefc_pkg::HS_DATA;
    logic        i_ref_clk, i_rst, psel, penable, pwrite, o_pready, o_pslverr, o_hs_valid;
    logic        o_tx_data1, o_engine_en, o_irq, tok, iack, rdone, crc, d1, stp, bv, err, tx1;
    logic [9:0]  paddr;
    logic [31:0] pwdata, o_prdata, rd;
    logic [1:0]  o_hs_code;
    logic [2:0]  o_fifo_ep, ep, ans, fep;
    logic [7:0]  rxb;
    logic [7:0]  pair_sel [4] = '{8'h82, 8'h02, 8'h84, 8'h04};
    int          fails = 0;
    int          cmp_count = 0;
    uefc_endpoint_ctrl uefc_endpoint_ctrl_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_tok_in(tok), .i_in_ack(iack), .i_rx_done(rdone), .i_rx_crc_ok(crc),
        .i_rx_data1(d1), .i_rx_setup(stp), .i_ep(ep), .i_rx_byte_valid(bv), .i_rx_byte(rxb),
        .o_hs_valid(o_hs_valid), .o_hs_code(o_hs_code), .o_tx_data1(o_tx_data1),
        .o_fifo_ep(o_fifo_ep), .o_engine_en(o_engine_en), .o_irq(o_irq));
    uefc_host_model host_i (.i_ref_clk(i_ref_clk), .i_hs_valid(o_hs_valid),
        .i_hs_code(o_hs_code), .i_tx_data1(o_tx_data1), .i_fifo_ep(o_fifo_ep),
        .o_tok_in(tok), .o_in_ack(iack), .o_rx_done(rdone), .o_crc_ok(crc), .o_data1(d1),
        .o_setup(stp), .o_ep(ep), .o_byte_vld(bv), .o_byte(rxb));
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    task automatic print_verdict;
        $display("compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge i_ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 16);
        rd = o_prdata;
        err = o_pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            fails++;
            print_verdict();
        end
        @(posedge i_ref_clk);
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask : rdc
    task automatic hev(input logic [2:0] kind, input logic [2:0] e, input logic [1:0] code);
        host_i.ev(kind, e, 1'b0, ans, tx1, fep);
        if (kind != 3'h1) chk(32'(ans), {29'h0, 1'b1, code});
    endtask : hev
    task automatic irqchk(input logic exp);
        // Interrupt follows status by a cycle
        repeat (2) @(posedge i_ref_clk);
        chk(32'(o_irq), 32'(exp));
    endtask : irqchk
    initial begin
        {psel, penable, pwrite, i_rst} = 4'h1;
        paddr = 10'h000;
        pwdata = 32'h0;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rdc(CTL, 8'h08);
        rdc(SV, 8'h00);
        bus(1'b0, 8'h10, 8'h00);
        chk(32'(err), 32'h1);
        $display("test reset done");
        wr(LINK, 8'h01);
        wr(SEL, 8'h81);
        hev(3'h0, 3'h1, NAK);
        wr(SIZE, 8'h40);
        rdc(CTL, 8'h09);
        hev(3'h0, 3'h1, DATA);
        chk(32'(tx1), 32'h0);
        hev(3'h1, 3'h1, ACK);
        rdc(CTL, 8'h0A);
        wr(IMSK, 8'h01);
        irqchk(1'b1);
        wr(IST, 8'h01);
        irqchk(1'b0);
        $display("test in done");
        wr(LINK, 8'h00);
        wr(LINK, 8'h01);
        rdc(CTL, 8'h08);
        chk(32'(o_engine_en), 32'h1);
        wr(CTL, 8'h0A);
        rdc(CTL, 8'h0A);
        wr(CTL, 8'h00);
        hev(3'h0, 3'h1, NAK);
        wr(CTL, 8'hFC);
        rdc(CTL, 8'h0C);
        hev(3'h0, 3'h1, STALL);
        wr(CTL, 8'h08);
        hev(3'h0, 3'h5, NAK);
        $display("test control done");
        wr(PAIR, 8'h01);
        wr(SIZE, 8'h40);
        wr(SIZE, 8'h40);
        hev(3'h0, 3'h1, DATA);
        chk(32'(fep), 32'h1);
        hev(3'h1, 3'h1, ACK);
        hev(3'h0, 3'h1, DATA);
        chk(32'(fep), 32'h2);
        chk(32'(tx1), 32'h1);
        hev(3'h1, 3'h1, ACK);
        for (int k = 0; k < 4; k++) begin
            wr(PAIR, 8'h01 << k);
            wr(SEL, pair_sel[k]);
            wr(CTL, 8'h0C);
            rdc(CTL, 8'h00);
        end
        wr(PAIR, 8'h00);
        rdc(CTL, 8'h08);
        $display("test pairing done");
        wr(SEL, 8'h02);
        wr(IST, 8'h0F);
        wr(IMSK, 8'h02);
        hev(3'h2, 3'h2, ACK);
        irqchk(1'b1);
        rdc(CTL, 8'h0B);
        wr(IST, 8'h02);
        irqchk(1'b0);
        wr(SIZE, 8'h00);
        hev(3'h2, 3'h2, ACK);
        rdc(IST, 8'h00);
        wr(CTL, 8'h02);
        wr(CTL, 8'h0A);
        rdc(CTL, 8'h08);
        $display("test out done");
        host_i.bytes(8'hA0);
        hev(3'h3, 3'h0, ACK);
        for (int k = 0; k < 8; k++) begin
            wr(SIX, 8'(k));
            rdc(SV, 8'hA0 + 8'(k));
        end
        wr(SIX, 8'hFF);
        rdc(SIX, 8'h07);
        $display("test setup done");
        print_verdict();
    end
endmodule : usb_endpoint_fifo_control_tb
`default_nettype wire
